// ---- shared/supply_monitor_pkg.sv ----
// constants for the supply drop detector control block
//
// Overview of operation
// - writing enable one powers the detector up
// - writing enable zero powers the detector down
// - stable flag reads one only when armed
// - four-bit trip code; 1111 external, 0000/0001 reserved
// - supply-low flag set only after reference stable
// - excursions ignored during reference start-up
package supply_monitor_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [1:0] CONTROL_ADDR   = 2'h0;    // control and status byte
    localparam logic [1:0] IRQ_STAT_ADDR  = 2'h1;    // sticky events, read clears
    localparam logic [1:0] IRQ_MASK_ADDR  = 2'h2;    // interrupt mask
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          STABLE_BIT    = 5;
    localparam int          ENABLE_BIT    = 4;
    localparam logic [3:0]  LEVEL_RESET   = 4'h5;
    localparam logic [3:0]  LEVEL_EXT     = 4'hf;    // external trip input
    localparam logic [3:0]  LEVEL_MIN     = 4'h2;    // lowest legal internal code
    localparam int          EV_DROP_BIT   = 0;       // supply drop event
    localparam int          EV_STABLE_BIT = 1;       // reference became stable
    // ------------------------------------------------------------
    // start-up timing
    // ------------------------------------------------------------
    localparam int          STARTUP_US    = 20;      // reference settle time, plain default
    localparam int          CLK_MHZ       = 20;
    localparam int          STARTUP_CYC   = STARTUP_US * CLK_MHZ;
    localparam logic [9:0]  STARTUP_LAST  = 10'(STARTUP_CYC - 1);
    // ------------------------------------------------------------
    // detector state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF    = 3'h1,
        ST_SETTLE = 3'h2,
        ST_ARMED  = 3'h4
    } det_state_t;
endpackage

// ---- core/supply_monitor.sv ----
// supply drop detector control register, start-up sequencer and interrupt
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor (
    input  wire logic       CLK_SYS_I,
    input  wire logic       RESET_I,
    input  wire logic [1:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic       COMPARE_LOW_I,    // analog comparator: supply below trip
    output logic      [7:0] RDATA_O,
    output logic            DETECTOR_POWER_O, // powers the analog circuit
    output logic      [3:0] TRIP_LEVEL_O,     // comparison point select
    output logic            EXT_INPUT_SEL_O,  // routes the external trip input
    output logic            IRQ_O
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    supply_monitor_pkg::det_state_t state, next_state;  // detector sequencer
    logic       enable,  next_enable;                   // power enable bit
    logic [3:0] level,   next_level;                    // trip level select
    logic [9:0] count,   next_count;                    // start-up counter
    logic [1:0] stat,    next_stat;                     // sticky events
    logic [1:0] mask,    next_mask;                     // interrupt mask
    logic [7:0] rdata,   next_rdata;                    // read data stage
    logic       irq,     next_irq;
    logic       s1, s2, s3;                             // comparator synchroniser
    logic       stable;                                 // armed decode
    logic [1:0] events;                                 // events this cycle

    // armed and still enabled: a disable write drops the flag in the same cycle,
    // so software never reads stable beside a cleared enable
    assign stable = (state == supply_monitor_pkg::ST_ARMED) && enable;

    // ------------------------------------------------------------
    // comparator synchroniser: a change counts once s2 and s3 agree
    // ------------------------------------------------------------
    logic low_seen, next_low_seen;
    always_comb begin
        next_low_seen = low_seen;
        if (s2 == s3) begin
            next_low_seen = s3;
        end
    end

    // ------------------------------------------------------------
    // register writes and sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_enable = enable;
        next_level  = level;
        next_mask   = mask;
        next_state  = state;
        next_count  = count;
        events      = 2'h0;
        if (WR_I && ADDR_I == supply_monitor_pkg::CONTROL_ADDR) begin
            next_enable = WDATA_I[supply_monitor_pkg::ENABLE_BIT];
            // reserved codes are kept out; previous level is retained
            if (WDATA_I[3:0] >= supply_monitor_pkg::LEVEL_MIN) begin
                next_level = WDATA_I[3:0];
            end
        end
        if (WR_I && ADDR_I == supply_monitor_pkg::IRQ_MASK_ADDR) begin
            next_mask = WDATA_I[1:0];
        end
        case (state)
            supply_monitor_pkg::ST_OFF: begin
                next_count = 10'h000;
                if (enable) begin
                    next_state = supply_monitor_pkg::ST_SETTLE;
                end
            end
            supply_monitor_pkg::ST_SETTLE: begin
                // drops are not watched while the reference settles
                if (!enable) begin
                    next_state = supply_monitor_pkg::ST_OFF;
                end else if (count == supply_monitor_pkg::STARTUP_LAST) begin
                    next_state = supply_monitor_pkg::ST_ARMED;
                    events[supply_monitor_pkg::EV_STABLE_BIT] = 1'b1;
                end else begin
                    next_count = count + 10'h001;
                end
            end
            supply_monitor_pkg::ST_ARMED: begin
                if (!enable) begin
                    next_state = supply_monitor_pkg::ST_OFF;
                end else if (low_seen) begin
                    events[supply_monitor_pkg::EV_DROP_BIT] = 1'b1;
                end
            end
            default: begin
                next_state = supply_monitor_pkg::ST_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------
    // status, read data and interrupt; a set wins over read clear
    // ------------------------------------------------------------
    always_comb begin
        next_stat  = stat;
        next_rdata = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                supply_monitor_pkg::CONTROL_ADDR: begin
                    // upper two bits read zero
                    next_rdata = {2'b00, stable, enable, level};
                end
                supply_monitor_pkg::IRQ_STAT_ADDR: begin
                    next_rdata = {6'h00, stat};
                    next_stat  = 2'h0;
                end
                supply_monitor_pkg::IRQ_MASK_ADDR: begin
                    next_rdata = {6'h00, mask};
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
        next_stat = next_stat | events;
        next_irq  = |(next_stat & next_mask);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        s1 <= COMPARE_LOW_I;
        s2 <= s1;
        s3 <= s2;
        if (RESET_I) begin
            state    <= supply_monitor_pkg::ST_OFF;
            enable   <= 1'b0;
            level    <= supply_monitor_pkg::LEVEL_RESET;
            count    <= 10'h000;
            stat     <= 2'h0;
            mask     <= 2'h0;
            rdata    <= 8'h00;
            irq      <= 1'b0;
            low_seen <= 1'b0;
        end else begin
            state    <= next_state;
            enable   <= next_enable;
            level    <= next_level;
            count    <= next_count;
            stat     <= next_stat;
            mask     <= next_mask;
            rdata    <= next_rdata;
            irq      <= next_irq;
            low_seen <= next_low_seen;
        end
    end

    // ------------------------------------------------------------
    // analog-facing outputs registered from the next values
    // ------------------------------------------------------------
    logic power_q, ext_q;
    logic [3:0] lvl_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            power_q <= 1'b0;
            lvl_q   <= supply_monitor_pkg::LEVEL_RESET;
            ext_q   <= 1'b0;
        end else begin
            power_q <= next_enable;
            lvl_q   <= next_level;
            ext_q   <= (next_level == supply_monitor_pkg::LEVEL_EXT);
        end
    end

    assign RDATA_O          = rdata;
    assign DETECTOR_POWER_O = power_q;
    assign TRIP_LEVEL_O     = lvl_q;
    assign EXT_INPUT_SEL_O  = ext_q;
    assign IRQ_O            = irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seq_enable_write;
        WR_I && ADDR_I == supply_monitor_pkg::CONTROL_ADDR && WDATA_I[4];
    endsequence
    sequence seq_disable_write;
        WR_I && ADDR_I == supply_monitor_pkg::CONTROL_ADDR && !WDATA_I[4];
    endsequence

    AST_POWER_UP: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        seq_enable_write |=> DETECTOR_POWER_O)
        else $error("power not raised after enable write");
    AST_POWER_DOWN: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        seq_disable_write |=> !DETECTOR_POWER_O && !stable ##1 !stable)
        else $error("power not dropped after disable write");
    AST_STABLE_NEEDS_POWER: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        stable |-> enable && $past(enable))
        else $error("stable without power");
    AST_EXT_SELECT: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        EXT_INPUT_SEL_O == (TRIP_LEVEL_O == 4'hf))
        else $error("external select mismatch");
    AST_NO_RESERVED: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        TRIP_LEVEL_O >= 4'h2)
        else $error("reserved trip code in use");
    AST_DROP_ARMED: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        $rose(stat[0]) |-> $past(stable))
        else $error("drop flag set while unarmed");
    AST_SETTLE_TIME: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        $rose(stable) |-> $past(count) == supply_monitor_pkg::STARTUP_LAST)
        else $error("armed before start-up elapsed");
    AST_RESET_VALUES: assert property (@(posedge CLK_SYS_I)
        $past(RESET_I) && !RESET_I |-> !enable && !stable && !DETECTOR_POWER_O && !IRQ_O
            && TRIP_LEVEL_O == supply_monitor_pkg::LEVEL_RESET && RDATA_O == 8'h00)
        else $error("wrong values after reset");
endmodule
`default_nettype wire

// ---- sim/supply_monitor_bench.sv ----
// self-checking bench for the supply drop detector control block
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_bench;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic       clk = 1'b0;      // 20 MHz system clock
    logic       rst = 1'b1;      // synchronous reset, active high
    logic [1:0] addr = 2'h0;     // register index
    logic [7:0] wdata = 8'h00;   // write data
    logic       wr = 1'b0;       // write strobe
    logic       rd = 1'b0;       // read strobe
    logic       cmp_low = 1'b0;  // comparator: supply below trip
    logic [7:0] rdata;
    logic       power;
    logic [3:0] level;
    logic       ext_sel;
    logic       irq;
    logic       rd_q = 1'b0;     // read taken at the last edge
    logic [7:0] exp_q[$];        // expected read data, oldest first
    logic [3:0] lvl;             // model of the trip level field
    int         errors = 0;
    int         n_compared = 0;
    int         cyc = 0;
    supply_monitor dut (
        .CLK_SYS_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .COMPARE_LOW_I(cmp_low), .RDATA_O(rdata),
        .DETECTOR_POWER_O(power), .TRIP_LEVEL_O(level),
        .EXT_INPUT_SEL_O(ext_sel), .IRQ_O(irq)
    );
    // clock: 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    // the expectation is queued before the strobe so the watcher finds it
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // comparator pulse, then time for the three-stage synchroniser
    task automatic drop_pulse(input int n);
        @(posedge clk);
        cmp_low <= 1'b1;
        repeat (n) @(posedge clk);
        cmp_low <= 1'b0;
        idle(6);
    endtask
    // read data stand only in the cycle after the strobe: look mid-cycle
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q) begin
            check(rdata, exp_q.pop_front());
        end
    end
    // hang guard: the whole run needs well under 3000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(24121));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({3'h0, power, level}, 8'h05);
        rd_reg(2'h0, 8'h05);
        rd_reg(2'h3, 8'h00);
        $display("reset values done");
        // every level code; upper bits random and must be ignored
        lvl = supply_monitor_pkg::LEVEL_RESET;
        for (int i = 0; i < 16; i++) begin
            wr_reg(2'h0, {3'($urandom_range(7)), 1'b0, 4'(i)});
            if (i >= 2) lvl = 4'(i);
            check({3'h0, ext_sel, level}, {3'h0, lvl == 4'hf, lvl});
            rd_reg(2'h0, {4'h0, lvl});
        end
        $display("level codes done");
        // enable with the supply already low: no event while settling
        wr_reg(2'h2, 8'h03);
        @(posedge clk);
        cmp_low <= 1'b1;
        wr_reg(2'h0, 8'hfe);
        check({7'h0, power}, 8'h01);
        rd_reg(2'h0, 8'h1e);
        for (int i = 0; i < 300; i++) begin
            check({7'h0, irq}, 8'h00);
            idle(1);
        end
        idle(supply_monitor_pkg::STARTUP_CYC - 280);
        rd_reg(2'h0, 8'h3e);
        @(posedge clk);
        cmp_low <= 1'b0;
        idle(6);
        check({7'h0, irq}, 8'h01);
        rd_reg(2'h1, 8'h03);
        idle(2);
        check({7'h0, irq}, 8'h00);
        rd_reg(2'h1, 8'h00);
        $display("start-up and drop done");
        // masked event sets status but not the line
        wr_reg(2'h2, 8'h00);
        drop_pulse(4);
        check({7'h0, irq}, 8'h00);
        rd_reg(2'h1, 8'h01);
        wr_reg(2'h2, 8'h01);
        drop_pulse(4);
        check({7'h0, irq}, 8'h01);
        rd_reg(2'h1, 8'h01);
        idle(2);
        check({7'h0, irq}, 8'h00);
        $display("interrupt mask done");
        // disable powers down and drops the stable flag
        wr_reg(2'h0, 8'h0e);
        check({7'h0, power}, 8'h00);
        rd_reg(2'h0, 8'h0e);
        // writes to the status and unmapped indexes must change nothing
        wr_reg(2'h1, 8'hff);
        wr_reg(2'h3, 8'h1f);
        rd_reg(2'h0, 8'h0e);
        rd_reg(2'h1, 8'h00);
        $display("disable done");
        // reset in mid-run with the detector powered must clear it again
        wr_reg(2'h0, 8'h17);
        check({3'h0, power, level}, 8'h17);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({3'h0, power, level}, 8'h05);
        check({7'h0, irq}, 8'h00);
        rd_reg(2'h0, 8'h05);
        $display("mid-run reset done");
        idle(2);
        close_out();
    end
endmodule
`default_nettype wire
